// ==== rtl/oslc_top.sv ====
// control logic for eight serial ports: line modes, registers, shared interrupt
//
// Summary of operation
// - two select inputs pick each port's line mode
// - differential modes keep rxd receiver always enabled
// - rs-422 keeps txd driver always enabled
// - rs-485 normal: control bit one disables driver
// - rs-485 inverted: control bit one enables driver
// - handshake use in differential modes keeps cts receiver, rts driver on
// - one shareable interrupt line serves all ports
// - no request unless source enabled for port
// - four sources: rx, tx empty, lsr, msr
// - memory mapped, uart layout plus extra registers
`timescale 1ns/100ps
module oslc_top
    import oslc_pkg::*;
#(
    parameter int N_PORTS = NPORT
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // register bus
    input oslc_bus_t i_bus,
    output logic [DW-1:0] o_rdata,
    // mode select inputs, one bit per port, closed = 1
    input wire logic [N_PORTS-1:0] i_mode_a,
    input wire logic [N_PORTS-1:0] i_mode_b,
    // interrupt events from the uart cores
    input oslc_evt_t [N_PORTS-1:0] i_evt,
    // transceiver controls
    output oslc_line_t [N_PORTS-1:0] o_line,
    // shared interrupt, level and open-drain pin
    output logic o_irq,
    input wire logic i_inta_n_i,
    output logic o_inta_n_o,
    output logic o_inta_oe
);

    localparam int NB = N_PORTS * NSRC;

    // per-port registers
    logic [7:0] mcr_r [N_PORTS];
    logic [7:0] mcr_nxt [N_PORTS];
    logic [3:0] ier_r [N_PORTS];
    logic [3:0] ier_nxt [N_PORTS];
    logic [N_PORTS-1:0] hs_r;
    logic [N_PORTS-1:0] hs_nxt;
    oslc_mode_t mode_r [N_PORTS];
    oslc_mode_t mode_nxt [N_PORTS];

    // bus and interrupt state
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [NB-1:0] en_flat;
    logic [NB-1:0] stat;
    logic [NB-1:0] clr;
    logic [NB-1:0] pending;

    // address decode
    logic is_port;
    logic [2:0] psel;
    logic [3:0] pidx;
    logic pvalid;

    always_comb begin
        is_port = ~i_bus.addr[7];
        psel = i_bus.addr[6:4];
        pidx = i_bus.addr[3:0];
        pvalid = is_port && (int'(psel) < N_PORTS);
    end

    // enable bits laid out like the status bits
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            en_flat[p*NSRC +: NSRC] = ier_r[p];
        end
    end

    // mode selects are sampled every cycle, so a change takes effect live
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            mode_nxt[p] = oslc_mode_t'({i_mode_b[p], i_mode_a[p]});
        end
    end

    // register writes and w1c clears
    always_comb begin
        mcr_nxt = mcr_r;
        ier_nxt = ier_r;
        hs_nxt = hs_r;
        clr = '0;
        if (i_bus.wr) begin
            if (pvalid) begin
                unique case (pidx)
                    IDX_IRQ_EN: ier_nxt[psel] = i_bus.wdata[3:0];
                    IDX_MODEM_CTL: mcr_nxt[psel] = i_bus.wdata[7:0];
                    IDX_PORT_STAT: clr[{psel, 2'b00} +: NSRC] = i_bus.wdata[3:0];
                    IDX_PORT_CFG: hs_nxt[psel] = i_bus.wdata[CFG_HS_BIT];
                    default: ;
                endcase
            end else if (!is_port) begin
                unique case (i_bus.addr)
                    ADDR_GLB_STAT: clr = i_bus.wdata[NB-1:0];
                    ADDR_GLB_MASK: begin
                        for (int p = 0; p < N_PORTS; p++) begin
                            ier_nxt[p] = i_bus.wdata[p*NSRC +: NSRC];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // read data exist only in the cycle after the read strobe
    always_comb begin
        rdata_nxt = '0;
        if (i_bus.rd) begin
            if (pvalid) begin
                unique case (pidx)
                    IDX_IRQ_EN: rdata_nxt[3:0] = ier_r[psel];
                    IDX_MODEM_CTL: rdata_nxt[7:0] = mcr_r[psel];
                    IDX_PORT_STAT: rdata_nxt[3:0] = stat[{psel, 2'b00} +: NSRC];
                    IDX_PORT_CFG: begin
                        rdata_nxt[CFG_HS_BIT] = hs_r[psel];
                        rdata_nxt[CFG_MODE_LSB +: 2] = mode_r[psel];
                    end
                    default: ;
                endcase
            end else if (!is_port) begin
                unique case (i_bus.addr)
                    ADDR_GLB_STAT: rdata_nxt[NB-1:0] = stat;
                    ADDR_GLB_MASK: rdata_nxt[NB-1:0] = en_flat;
                    ADDR_GLB_LINE: begin
                        rdata_nxt[LINE_IRQ_BIT] = irq_r;
                        rdata_nxt[LINE_PIN_BIT] = ~i_inta_n_i;
                    end
                    default: ;
                endcase
            end
        end
    end

    // one merged request for every port
    always_comb begin
        pending = stat & en_flat;
        irq_nxt = |pending;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            for (int p = 0; p < N_PORTS; p++) begin
                mcr_r[p] <= MCR_RST;
                ier_r[p] <= IER_RST;
                mode_r[p] <= MODE_RS232;
            end
            hs_r <= {N_PORTS{CFG_HS_RST}};
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else begin
            mcr_r <= mcr_nxt;
            ier_r <= ier_nxt;
            mode_r <= mode_nxt;
            hs_r <= hs_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // event flags hold even while disabled, so enabling later raises them
    oslc_sticky #(
        .W(NB)
    ) u_status (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_set(i_evt),
        .i_clr(clr),
        .o_flag(stat)
    );

    generate
        for (genvar g = 0; g < N_PORTS; g++) begin : g_port
            oslc_port u_port (
                .i_clock(i_clock),
                .i_srst(i_srst),
                .i_mode(mode_r[g]),
                .i_rts_ctl(mcr_r[g][MCR_RTS_BIT]),
                .i_hs_use(hs_r[g]),
                .o_line(o_line[g])
            );
        end
    endgenerate

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;
    // open drain: only ever pull low, so other boards can share the wire
    assign o_inta_n_o = 1'b0;
    assign o_inta_oe = irq_r;

    a_irq_follows_pend: assert property (@(posedge i_clock) disable iff (i_srst)
        (|(stat & en_flat)) |=> o_irq)
        else $error("interrupt missing while source pends");

    a_irq_needs_enable: assert property (@(posedge i_clock) disable iff (i_srst)
        !(|(stat & en_flat)) |=> !o_irq)
        else $error("interrupt without enabled source");

    a_event_sets_stat: assert property (@(posedge i_clock) disable iff (i_srst)
        (|i_evt) |=> ((stat & $past(i_evt)) == $past(i_evt)))
        else $error("event did not set status");

    a_pin_shared_drive: assert property (@(posedge i_clock) disable iff (i_srst)
        (o_inta_oe == o_irq) && !o_inta_n_o)
        else $error("shared pin not open drain");

    a_mask_read_back: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && i_bus.addr == ADDR_GLB_MASK) |=> (o_rdata[NB-1:0] == $past(en_flat)))
        else $error("mask read data wrong");

    a_rdata_one_cycle: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_bus.rd |=> (o_rdata == '0))
        else $error("read data outside answer cycle");

    // register writes land one edge after the strobe
    a_ier_port_write: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && pvalid && pidx == IDX_IRQ_EN)
            |=> (ier_r[$past(psel)] == $past(i_bus.wdata[3:0])))
        else $error("port enable write lost");

    a_mcr_port_write: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && pvalid && pidx == IDX_MODEM_CTL)
            |=> (mcr_r[$past(psel)] == $past(i_bus.wdata[7:0])))
        else $error("modem control write lost");

    a_hs_port_write: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && pvalid && pidx == IDX_PORT_CFG)
            |=> (hs_r[$past(psel)] == $past(i_bus.wdata[CFG_HS_BIT])))
        else $error("handshake write lost");

    a_mask_write: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && i_bus.addr == ADDR_GLB_MASK)
            |=> (en_flat == $past(i_bus.wdata[NB-1:0])))
        else $error("global enable write lost");

    a_enable_hold: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_bus.wr |=> (en_flat == $past(en_flat)))
        else $error("enables changed without a write");

    a_wr_unmapped: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && !is_port && i_bus.addr > ADDR_GLB_LINE) |=> (en_flat == $past(en_flat)))
        else $error("unmapped write changed enables");

    // status flags: set only by events, cleared only by written ones
    a_stat_needs_event: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_srst |=> ((stat & ~$past(stat) & ~$past(i_evt)) == '0))
        else $error("status set without event");

    a_stat_holds: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_bus.wr |=> ((stat & $past(stat)) == $past(stat)))
        else $error("status lost without a clear");

    a_glb_clear: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && i_bus.addr == ADDR_GLB_STAT)
            |=> ((stat & $past(i_bus.wdata[NB-1:0]) & ~$past(i_evt)) == '0))
        else $error("global status clear failed");

    a_glb_clear_keeps: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && i_bus.addr == ADDR_GLB_STAT)
            |=> ((stat & $past(stat) & ~$past(i_bus.wdata[NB-1:0]))
                == ($past(stat) & ~$past(i_bus.wdata[NB-1:0]))))
        else $error("global clear hit other bits");

    a_port_clear: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.wr && pvalid && pidx == IDX_PORT_STAT)
            |=> ((stat[{$past(psel), 2'b00} +: NSRC] & $past(i_bus.wdata[3:0])
                & ~$past(i_evt[psel])) == '0))
        else $error("port status clear failed");

    // read data mirror the addressed register one cycle later
    a_rdata_ier_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && pvalid && pidx == IDX_IRQ_EN)
            |=> (o_rdata == {{(DW-4){1'b0}}, $past(ier_r[psel])}))
        else $error("port enable read wrong");

    a_rdata_mcr_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && pvalid && pidx == IDX_MODEM_CTL)
            |=> (o_rdata == {{(DW-8){1'b0}}, $past(mcr_r[psel])}))
        else $error("modem control read wrong");

    a_rdata_pstat_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && pvalid && pidx == IDX_PORT_STAT)
            |=> (o_rdata == {{(DW-NSRC){1'b0}}, $past(stat[{psel, 2'b00} +: NSRC])}))
        else $error("port status read wrong");

    a_rdata_cfg_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && pvalid && pidx == IDX_PORT_CFG)
            |=> (o_rdata[CFG_MODE_LSB +: 2] == $past(mode_r[psel])
                && o_rdata[CFG_HS_BIT] == $past(hs_r[psel])))
        else $error("port config read wrong");

    a_rdata_stat_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && i_bus.addr == ADDR_GLB_STAT) |=> (o_rdata[NB-1:0] == $past(stat)))
        else $error("global status read wrong");

    a_rdata_line_read: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && i_bus.addr == ADDR_GLB_LINE)
            |=> (o_rdata[LINE_IRQ_BIT] == $past(irq_r)
                && o_rdata[LINE_PIN_BIT] == !$past(i_inta_n_i)))
        else $error("line status read wrong");

    a_rdata_unmapped: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_bus.rd && !is_port && i_bus.addr > ADDR_GLB_LINE) |=> (o_rdata == '0))
        else $error("unmapped read not zero");

    // per-port checks, pins and registers reach the lines in two edges
    generate
        for (genvar g = 0; g < N_PORTS; g++) begin : g_check
            a_mode_follows_pins: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_srst |=> (mode_r[g] == $past({i_mode_b[g], i_mode_a[g]})))
                else $error("mode select not captured");

            a_rts_pin_level: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_srst |=> (o_line[g].rts == !$past(mcr_r[g][MCR_RTS_BIT])))
                else $error("rts pin level wrong");

            a_hs_line_follows: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_srst |=> (o_line[g].rts_drv_en
                    == ($past(hs_r[g]) && ($past(mode_r[g]) != MODE_RS232))))
                else $error("handshake driver enable wrong");

            a_rx_line_follows: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_srst |=> (o_line[g].rxd_rcv_en == ($past(mode_r[g]) != MODE_RS232)))
                else $error("receiver enable wrong");

            a_mcr_hold: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_bus.wr |=> (mcr_r[g] == $past(mcr_r[g])))
                else $error("modem control changed without a write");

            a_hs_hold: assert property (@(posedge i_clock) disable iff (i_srst)
                !i_bus.wr |=> (hs_r[g] == $past(hs_r[g])))
                else $error("handshake bit changed without a write");
        end
    endgenerate

endmodule // oslc_top

// ==== shared/oslc_pkg.sv ====
// shared constants and types for the octal serial line-driver control block
package oslc_pkg;

    // port count and register bus widths
    localparam int NPORT = 8;
    localparam int NSRC = 4;
    localparam int AW = 8;
    localparam int DW = 32;

    // per-port register indices, port number sits in address bits [6:4]
    localparam logic [3:0] IDX_IRQ_EN = 4'h1;
    localparam logic [3:0] IDX_MODEM_CTL = 4'h4;
    localparam logic [3:0] IDX_PORT_STAT = 4'h8;
    localparam logic [3:0] IDX_PORT_CFG = 4'h9;

    // global registers, address bit 7 set
    localparam logic [7:0] ADDR_GLB_STAT = 8'h80;
    localparam logic [7:0] ADDR_GLB_MASK = 8'h81;
    localparam logic [7:0] ADDR_GLB_LINE = 8'h82;

    // field positions
    localparam int MCR_RTS_BIT = 1;
    localparam int CFG_HS_BIT = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam int LINE_IRQ_BIT = 0;
    localparam int LINE_PIN_BIT = 1;

    // interrupt source bit positions inside a port nibble
    localparam int SRC_RX_AVAIL = 0;
    localparam int SRC_TX_EMPTY = 1;
    localparam int SRC_LSR_CHG = 2;
    localparam int SRC_MSR_CHG = 3;

    // reset values
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic CFG_HS_RST = 1'b0;

    // line mode, code equals {select_b, select_a} with closed = 1
    typedef enum logic [1:0] {
        MODE_RS232,
        MODE_RS485,
        MODE_RS485_INV,
        MODE_RS422
    } oslc_mode_t;

    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } oslc_bus_t;

    // one port's interrupt events from its uart core, rx_avail in bit 0
    typedef struct packed {
        logic msr_change;
        logic lsr_change;
        logic tx_empty;
        logic rx_avail;
    } oslc_evt_t;

    // one port's transceiver controls
    typedef struct packed {
        logic rts;
        logic rts_drv_en;
        logic cts_rcv_en;
        logic txd_drv_en;
        logic rxd_rcv_en;
    } oslc_line_t;

endpackage

// ==== rtl/oslc_sticky.sv ====
// sticky event flags, write one to clear, set wins
`timescale 1ns/100ps
module oslc_sticky
    import oslc_pkg::*;
#(
    parameter int W = NPORT * NSRC
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // events and clears
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    // flags
    output logic [W-1:0] o_flag
);

    logic [W-1:0] flag_r;
    logic [W-1:0] flag_nxt;

    // set after clear so an event in the clear cycle survives
    always_comb begin
        flag_nxt = (flag_r & ~i_clr) | i_set;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign o_flag = flag_r;

    a_set_beats_clear: assert property (@(posedge i_clock) disable iff (i_srst)
        (|(i_set & i_clr)) |=> ((o_flag & $past(i_set)) == $past(i_set)))
        else $error("event lost during clear");

endmodule // oslc_sticky

// ==== rtl/oslc_port.sv ====
// per-port transceiver enable and rts polarity logic
`timescale 1ns/100ps
module oslc_port
    import oslc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // settings
    input oslc_mode_t i_mode,
    input wire logic i_rts_ctl,
    input wire logic i_hs_use,
    // transceiver controls
    output oslc_line_t o_line
);

    oslc_line_t line_r;
    oslc_line_t line_nxt;
    logic diff_mode;

    always_comb begin
        diff_mode = (i_mode != MODE_RS232);
        line_nxt = '0;
        // uart rts pin is the inverse of the control bit
        line_nxt.rts = ~i_rts_ctl;
        line_nxt.rxd_rcv_en = diff_mode;
        line_nxt.cts_rcv_en = diff_mode & i_hs_use;
        line_nxt.rts_drv_en = diff_mode & i_hs_use;
        unique case (i_mode)
            MODE_RS232: line_nxt.txd_drv_en = 1'b0;
            MODE_RS485: line_nxt.txd_drv_en = ~i_rts_ctl;
            MODE_RS485_INV: line_nxt.txd_drv_en = i_rts_ctl;
            MODE_RS422: line_nxt.txd_drv_en = 1'b1;
        endcase
    end

    // rs-232 mode leaves the differential transceivers idle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            line_r <= '0;
            line_r.rts <= 1'b1;
        end else begin
            line_r <= line_nxt;
        end
    end

    assign o_line = line_r;

    a_rx_always_on: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode != MODE_RS232) |=> o_line.rxd_rcv_en)
        else $error("receiver off in differential mode");

    a_tx_422_on: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode == MODE_RS422) |=> o_line.txd_drv_en)
        else $error("driver off in rs-422 mode");

    a_tx_485_norm: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode == MODE_RS485)
            |=> (o_line.txd_drv_en == !$past(i_rts_ctl) && o_line.rts == o_line.txd_drv_en))
        else $error("normal rts enable wrong");

    a_tx_485_inv: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode == MODE_RS485_INV)
            |=> (o_line.txd_drv_en == $past(i_rts_ctl) && o_line.rts != o_line.txd_drv_en))
        else $error("inverted rts enable wrong");

    a_hs_pins_on: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode != MODE_RS232 && i_hs_use) |=> (o_line.cts_rcv_en && o_line.rts_drv_en))
        else $error("handshake transceivers off");

    a_rs232_idle: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_mode == MODE_RS232) |=> !(o_line.txd_drv_en || o_line.rxd_rcv_en || o_line.rts_drv_en))
        else $error("rs-232 mode drives differential lines");

endmodule // oslc_port

// ==== verification/oslc_line_partner.sv ====
// far side model: shared interrupt wire with pull-up and one more device on it
`timescale 1ns/100ps
module oslc_line_partner
    import oslc_pkg::*;
(
    // our open-drain pin
    input wire logic i_inta_n_o,
    input wire logic i_inta_oe,
    // another device sharing the wire
    input wire logic i_other_oe,
    // wire level seen by every party
    output logic o_wire_n
);
    // pull-up wins only when nobody pulls low
    assign o_wire_n = ((i_inta_oe && !i_inta_n_o) || i_other_oe) ? 1'b0 : 1'b1;
endmodule // oslc_line_partner

// ==== verification/oslc_top_tb_top.sv ====
// self-checking bench for the line-driver control block
`timescale 1ns/100ps
module oslc_top_tb_top
    import oslc_pkg::*;
;
    logic i_clock;
    logic i_srst;
    oslc_bus_t bus;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    oslc_evt_t [7:0] evt;
    oslc_line_t [7:0] line;
    logic [DW-1:0] rdata;
    logic irq;
    logic wire_n;
    logic inta_n_o;
    logic inta_oe;
    logic other_oe;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    oslc_top u_oslc_top (
        .i_clock(i_clock), .i_srst(i_srst), .i_bus(bus), .o_rdata(rdata),
        .i_mode_a(mode_a), .i_mode_b(mode_b), .i_evt(evt), .o_line(line),
        .o_irq(irq), .i_inta_n_i(wire_n), .o_inta_n_o(inta_n_o), .o_inta_oe(inta_oe)
    );

    oslc_line_partner u_oslc_line_partner (
        .i_inta_n_o(inta_n_o), .i_inta_oe(inta_oe), .i_other_oe(other_oe), .o_wire_n(wire_n)
    );

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_line(input int p, input logic [4:0] exp);
        cmp_word({27'h0, line[p]}, {27'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge i_clock);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        bus <= {1'b0, 1'b1, a, 32'h0};
        @(posedge i_clock);
        bus <= '0;
        #1;
        cmp_word(rdata, exp);
    endtask

    // one cycle of events, bit p*4+src
    task automatic pulse(input logic [31:0] m);
        @(posedge i_clock);
        evt <= m;
        @(posedge i_clock);
        evt <= '0;
    endtask

    task automatic settle();
        @(posedge i_clock);
        #1;
    endtask

    function automatic logic [4:0] exp_line(input int m, input int b1, input int hs);
        logic txd;
        txd = (m == 3) || (m == 1 && b1 == 0) || (m == 2 && b1 == 1);
        return {b1 == 0, hs == 1 && m != 0, hs == 1 && m != 0, txd, m != 0};
    endfunction

    // hang guard, whole run needs well under a thousand cycles
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        int s;
        int t;
        i_srst = 1'b1;
        bus = '0;
        mode_a = 8'h00;
        mode_b = 8'h00;
        evt = '0;
        other_oe = 1'b0;
        repeat (6) @(posedge i_clock);
        i_srst <= 1'b0;
        #1;
        for (int q = 0; q < 8; q++) cmp_line(q, 5'h10);
        cmp_word({31'h0, irq}, 32'h0);
        rd(8'h51, 32'h0);
        // every mode, both rts bit values, handshake on and off
        for (int m = 0; m < 4; m++) begin
            for (int b1 = 0; b1 < 2; b1++) begin
                for (int hs = 0; hs < 2; hs++) begin
                    @(posedge i_clock);
                    mode_a <= {8{m[0]}};
                    mode_b <= {8{m[1]}};
                    wr(8'h34, 32'(b1 * 2));
                    wr(8'h39, 32'(hs));
                    settle();
                    cmp_line(3, exp_line(m, b1, hs));
                    for (int q = 0; q < 8; q++) if (q != 3) cmp_line(q, exp_line(m, 0, 0));
                    rd(8'h34, 32'(b1 * 2));
                    rd(8'h39, 32'(m * 16 + hs));
                end
            end
        end
        // each source alone, with a disabled neighbour pending
        for (s = 0; s < 4; s++) begin
            t = (s + 1) % 4;
            wr(8'h51, 32'(1 << s));
            pulse(32'(1 << (20 + s)));
            settle();
            cmp_word({31'h0, irq}, 32'h1);
            rd(8'h82, 32'h3);
            rd(8'h80, 32'(1 << (20 + s)));
            pulse(32'(1 << (20 + t)));
            rd(8'h58, 32'((1 << s) | (1 << t)));
            wr(8'h58, 32'(1 << s));
            settle();
            cmp_word({31'h0, irq}, 32'h0);
            wr(8'h58, 32'(1 << t));
        end
        // two ports pending, interrupt holds until both clear
        wr(8'h81, 32'h0000_0011);
        rd(8'h81, 32'h0000_0011);
        rd(8'h51, 32'h0);
        pulse(32'h0000_0011);
        settle();
        cmp_word({30'h0, inta_oe, irq}, 32'h3);
        cmp_word({31'h0, inta_n_o}, 32'h0);
        wr(8'h80, 32'h0000_0001);
        settle();
        cmp_word({31'h0, irq}, 32'h1);
        wr(8'h80, 32'h0000_0010);
        settle();
        cmp_word({30'h0, inta_oe, irq}, 32'h0);
        // event and clear in one cycle, the event is kept
        @(posedge i_clock);
        evt <= 32'h0000_0001;
        bus <= {1'b1, 1'b0, 8'h80, 32'h0000_0001};
        @(posedge i_clock);
        evt <= '0;
        bus <= '0;
        rd(8'h80, 32'h0000_0001);
        settle();
        cmp_word({31'h0, irq}, 32'h1);
        wr(8'h80, 32'h0000_0001);
        settle();
        cmp_word({31'h0, irq}, 32'h0);
        // another device pulls the shared wire
        @(posedge i_clock);
        other_oe <= 1'b1;
        rd(8'h82, 32'h2);
        @(posedge i_clock);
        other_oe <= 1'b0;
        // unmapped places, then the idle line status
        wr(8'h83, 32'hFFFF_FFFF);
        rd(8'h83, 32'h0);
        rd(8'h7F, 32'h0);
        rd(8'h82, 32'h0);
        give_verdict();
    end
endmodule // oslc_top_tb_top
